//--- eepc_asserts.sv
`timescale 1ns/1ps
module eepc_asserts
    import eepc_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic MEM_REQ,
    input wire logic MEM_WE,
    input wire logic [15:0] MEM_ADDR,
    input wire logic [7:0] EPROM_RDATA,
    input wire logic [7:0] MEM_RDATA,
    input wire logic STOP_ENTRY,
    input wire logic CAN_SLEEP,
    input wire logic CAN_WAKE,
    input wire logic WIRED_OR_MASK_OPTION,
    input wire logic WIRED_OR_IRQ_PIN_N,
    input wire logic WIRED_OR_IRQ,
    input wire logic EPROM_PROGRAM_ACTIVE,
    input wire eepc_ep_latch_t EPROM_LATCH,
    input wire eepc_ctrl_t CTRL_VIEW
);
    eepc_ctrl_t c;
    assign c = CTRL_VIEW;

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);

    sequence ep_read_s(logic lat);
        MEM_REQ && !MEM_WE && c.eprom_latch_enable == lat
            && MEM_ADDR >= 16'h0400 && MEM_ADDR <= 16'h7DFF;
    endsequence
    sequence woi_armed_s;
        c.wired_or_irq_enable && WIRED_OR_MASK_OPTION && !WIRED_OR_IRQ_PIN_N;
    endsequence

    read_zero_a: assert property (ep_read_s(1'b1) |=> MEM_RDATA == 8'h00)
        else $error("eprom read not zero while latched");
    read_pass_a: assert property (ep_read_s(1'b0) |=> MEM_RDATA == $past(EPROM_RDATA))
        else $error("eprom read data altered");
    stop_clear_a: assert property (STOP_ENTRY |=> !c.eprom_latch_enable && !c.eeprom_latch_enable)
        else $error("stop left a latch enable set");
    pgm_needs_bytes_a: assert property ($rose(c.eprom_program_enable) |-> c.eprom_latch_enable && EPROM_LATCH.valid != 16'h0000)
        else $error("program enable set without latched byte");
    prog_active_a: assert property (c.eprom_program_enable [*2] |-> EPROM_PROGRAM_ACTIVE)
        else $error("programming state not shown");
    ee_clear_a: assert property (!c.eeprom_latch_enable |-> !c.eeprom_erase_select && !c.eeprom_pump_enable)
        else $error("erase or pump set without eeprom latch");
    pump_fall_a: assert property ($fell(c.eeprom_pump_enable) |-> !c.eeprom_latch_enable)
        else $error("pump cleared while latch held");
    era_frozen_a: assert property (c.eeprom_pump_enable && $past(c.eeprom_pump_enable) |-> $stable(c.eeprom_erase_select))
        else $error("erase select changed during operation");
    wired_or_irq_enable_forced_a: assert property (!WIRED_OR_MASK_OPTION [*2] |-> !c.wired_or_irq_enable)
        else $error("wired-or enable set without option");
    woi_irq_a: assert property (woi_armed_s [*2] |-> WIRED_OR_IRQ)
        else $error("wired-or request lost");
    woi_off_a: assert property (!c.wired_or_irq_enable [*2] |-> !WIRED_OR_IRQ)
        else $error("wired-or request while disabled");
    can_set_a: assert property (CAN_SLEEP |=> c.can_sleep_flag)
        else $error("sleep flag not set");
    can_clr_a: assert property (CAN_WAKE && !CAN_SLEEP |=> !c.can_sleep_flag)
        else $error("sleep flag not cleared");
endmodule // eepc_asserts

//--- eepc_cpu_model.sv
`timescale 1ns/1ps
module eepc_cpu_model
    import eepc_pkg::*;
(
    input wire logic clk,
    input wire logic mem_ack,
    input wire logic [7:0] mem_rdata,
    output logic mem_req,
    output logic mem_we,
    output logic [15:0] mem_addr,
    output logic [7:0] mem_wdata
);
    logic [7:0] rd;

    initial begin
        mem_req = 1'b0;
        mem_we = 1'b0;
        mem_addr = 16'h0000;
        mem_wdata = 8'h00;
    end

    // runs from ram: only data cycles, never a fetch while latching is on
    task automatic access(input logic w, input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        mem_req <= 1'b1;
        mem_we <= w;
        mem_addr <= a;
        mem_wdata <= d;
        @(posedge clk);
        mem_req <= 1'b0;
        do @(posedge clk); while (mem_ack !== 1'b1);
        rd = mem_rdata;
        mem_addr <= ~a;
        mem_wdata <= ~d;
    endtask
endmodule // eepc_cpu_model

//--- eepc_pkg.sv
// What this block does
// - decode main eprom array, vector bytes at top and one eprom option byte
// - eprom reads return zero while eprom latching is enabled
// - stop entry returns eprom to normal read mode
// - reset and stop clear eprom latch; clearing latch clears program enable
// - eprom array data passes unaltered so an erased byte reads zero
// - latched eprom bytes must share all address bits above the low four
// - repeated writes to one latched byte only accumulate one bits
// - latch on, program off: eprom writes capture address and up to 16 bytes
// - program enable sets only with latch on and a byte latched; zero ignored
// - eprom state decoded from latch and program enable bits
// - wired-or enable forced zero without mask option; cleared by reset
// - enable and option set: wired-or interrupts from pin and port b inputs
// - can sleep flag set on sleep entry, cleared on wake
// - erase select picks erase or program; frozen once address selected
// - eeprom latch on captures address and data; off forces select and pump low
// - reset and stop clear eeprom latch
// - pump sets only after data selected; clears only with latch
// - eeprom state decoded from erase select, latch and pump
// - upper eeprom region fails program or erase while protect bit clear
// - protect bit written to zero only while eeprom latch is set
package eepc_pkg;

    localparam logic [11:0] CTRL_INDEX = 12'h007;
    localparam logic [11:0] OPTS_INDEX = 12'h100;
    localparam logic [11:0] CTRL_BADDR = {CTRL_INDEX[9:0], 2'b00};
    localparam logic [11:0] OPTS_BADDR = {OPTS_INDEX[9:0], 2'b00};

    localparam logic [15:0] EP_MAIN_LO = 16'h0400;
    localparam logic [15:0] EP_MAIN_HI = 16'h7DFF;
    localparam logic [15:0] EP_VEC_LO = 16'h7FF0;
    localparam logic [15:0] EP_VEC_HI = 16'h7FFF;
    localparam logic [15:0] EP_OPT_ADDR = 16'h7FDE;
    localparam logic [15:0] EE_LO = 16'h0100;
    localparam logic [15:0] EE_HI = 16'h01FF;
    localparam logic [15:0] EE_PROT_LO = 16'h0120;

    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] OPTS_RESET = 8'h03;
    localparam logic [7:0] OPTS_USED = 8'h03;
    localparam int OPTS_PROTECT_BIT = 1;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    typedef enum logic [4:0] {
        RG_NONE = 5'b00001,
        RG_EPMAIN = 5'b00010,
        RG_EPVEC = 5'b00100,
        RG_EPOPT = 5'b01000,
        RG_EE = 5'b10000
    } eepc_region_t;

    typedef enum logic [2:0] {
        EP_READ = 3'b001,
        EP_LOAD = 3'b010,
        EP_PROG = 3'b100
    } eepc_ep_state_t;

    typedef enum logic [4:0] {
        EE_READ = 5'b00001,
        EE_LOAD = 5'b00010,
        EE_PROG = 5'b00100,
        EE_ERADDR = 5'b01000,
        EE_ERASE = 5'b10000
    } eepc_ee_state_t;

    typedef struct packed {
        logic wired_or_irq_enable;
        logic can_sleep_flag;
        logic eprom_latch_enable;
        logic eprom_program_enable;
        logic external_clock_output;
        logic eeprom_erase_select;
        logic eeprom_latch_enable;
        logic eeprom_pump_enable;
    } eepc_ctrl_t;

    typedef struct packed {
        logic [11:0] group;
        logic [15:0] valid;
        logic [127:0] data;
    } eepc_ep_latch_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
        logic erase;
        logic pump;
    } eepc_ee_op_t;

    function automatic eepc_region_t eepc_region(input logic [15:0] a);
        if (a >= EP_MAIN_LO && a <= EP_MAIN_HI) begin
            return RG_EPMAIN;
        end
        if (a >= EP_VEC_LO && a <= EP_VEC_HI) begin
            return RG_EPVEC;
        end
        if (a == EP_OPT_ADDR) begin
            return RG_EPOPT;
        end
        if (a >= EE_LO && a <= EE_HI) begin
            return RG_EE;
        end
        return RG_NONE;
    endfunction

    function automatic logic eepc_is_ep(input eepc_region_t r);
        return (r == RG_EPMAIN) || (r == RG_EPVEC) || (r == RG_EPOPT);
    endfunction

    function automatic eepc_ep_state_t eepc_ep_dec(input logic lat, input logic pgm);
        if (lat && pgm) begin
            return EP_PROG;
        end
        if (lat) begin
            return EP_LOAD;
        end
        return EP_READ;
    endfunction

    function automatic eepc_ee_state_t eepc_ee_dec(input logic era, input logic lat,
                                                    input logic pgm);
        case ({era, lat, pgm})
            3'b010: return EE_LOAD;
            3'b011: return EE_PROG;
            3'b110: return EE_ERADDR;
            3'b111: return EE_ERASE;
            default: return EE_READ;
        endcase
    endfunction

endpackage

//--- eepc_top.sv
`timescale 1ns/1ps
module eepc_top
    import eepc_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic MEM_REQ,
    input wire logic MEM_WE,
    input wire logic [15:0] MEM_ADDR,
    input wire logic [7:0] MEM_WDATA,
    output logic [7:0] MEM_RDATA,
    output logic MEM_ACK,
    input wire logic [7:0] EPROM_RDATA,
    input wire logic [7:0] EEPROM_RDATA,
    input wire logic STOP_ENTRY,
    input wire logic CAN_SLEEP,
    input wire logic CAN_WAKE,
    input wire logic WIRED_OR_MASK_OPTION,
    input wire logic WIRED_OR_IRQ_PIN_N,
    input wire logic [7:0] PORTB_IN,
    input wire logic [7:0] PORTB_DDR,
    output logic WIRED_OR_IRQ,
    output logic EXTERNAL_CLOCK_OUTPUT,
    output logic EPROM_PROGRAM_ACTIVE,
    output logic EPROM_FETCH_BLOCKED,
    output eepc_ep_latch_t EPROM_LATCH,
    output eepc_ee_op_t EEPROM_OP,
    output logic EEPROM_BLOCKED,
    output eepc_ctrl_t CTRL_VIEW
);

    eepc_ctrl_t ctrl_q;
    eepc_ctrl_t wr_bits;
    logic [7:0] opts_q;
    eepc_ep_latch_t ep_q;
    logic ee_sel_q;
    logic [7:0] ee_addr_q;
    logic [7:0] ee_data_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic [7:0] mem_rdata_q;
    logic mem_ack_q;
    logic woi_q;
    logic ep_prog_q;
    logic ep_block_q;
    eepc_ee_op_t ee_op_q;
    logic ee_blocked_q;

    logic setup;
    logic wr_ctrl;
    logic wr_opts;
    logic mapped;
    logic mem_wr;
    logic ep_lat_d;
    logic ee_lat_d;
    logic ee_upper;
    logic ee_fail;
    logic [3:0] slot;
    eepc_region_t region;
    eepc_ep_state_t ep_state;
    eepc_ee_state_t ee_state;

    // apb decode: request taken in the access cycle that sees pready high
    always_comb begin
        setup = PSEL && !PENABLE;
        mapped = (PADDR == CTRL_BADDR) || (PADDR == OPTS_BADDR);
        wr_ctrl = PSEL && PENABLE && pready_q && PWRITE && (PADDR == CTRL_BADDR);
        wr_opts = PSEL && PENABLE && pready_q && PWRITE && (PADDR == OPTS_BADDR);
        wr_bits = eepc_ctrl_t'(PWDATA[7:0]);
    end

    always_comb begin
        region = eepc_region(MEM_ADDR);
        mem_wr = MEM_REQ && MEM_WE;
        slot = MEM_ADDR[3:0];
        ep_state = eepc_ep_dec(ctrl_q.eprom_latch_enable,
                               ctrl_q.eprom_program_enable);
        ee_state = eepc_ee_dec(ctrl_q.eeprom_erase_select,
                               ctrl_q.eeprom_latch_enable,
                               ctrl_q.eeprom_pump_enable);
    end

    // next latch enables: stop wins over a software write
    always_comb begin
        if (STOP_ENTRY) begin
            ep_lat_d = 1'b0;
            ee_lat_d = 1'b0;
        end else if (wr_ctrl) begin
            ep_lat_d = wr_bits.eprom_latch_enable;
            ee_lat_d = wr_bits.eeprom_latch_enable;
        end else begin
            ep_lat_d = ctrl_q.eprom_latch_enable;
            ee_lat_d = ctrl_q.eeprom_latch_enable;
        end
    end

    // protection of the upper eeprom region
    always_comb begin
        ee_upper = ee_addr_q >= EE_PROT_LO[7:0];
        ee_fail = !opts_q[OPTS_PROTECT_BIT] && ee_upper;
    end

    // apb slave handshake, one wait-free access phase
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= setup;
            if (setup) begin
                pslverr_q <= !mapped;
                if (PADDR == CTRL_BADDR) begin
                    prdata_q <= {24'h00_0000, ctrl_q};
                end else if (PADDR == OPTS_BADDR) begin
                    prdata_q <= {24'h00_0000, opts_q & OPTS_USED};
                end else begin
                    prdata_q <= 32'h0000_0000;
                end
            end
        end
    end

    // wired-or enable and external clock output bit
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            ctrl_q.wired_or_irq_enable <= CTRL_RESET[7];
            ctrl_q.external_clock_output <= CTRL_RESET[3];
        end else begin
            if (!WIRED_OR_MASK_OPTION) begin
                ctrl_q.wired_or_irq_enable <= 1'b0;
            end else if (wr_ctrl) begin
                ctrl_q.wired_or_irq_enable <= wr_bits.wired_or_irq_enable;
            end
            if (wr_ctrl) begin
                ctrl_q.external_clock_output <= wr_bits.external_clock_output;
            end
        end
    end

    // can sleep flag follows the can module only; sleep wins over wake
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            ctrl_q.can_sleep_flag <= CTRL_RESET[6];
        end else if (CAN_SLEEP) begin
            ctrl_q.can_sleep_flag <= 1'b1;
        end else if (CAN_WAKE) begin
            ctrl_q.can_sleep_flag <= 1'b0;
        end
    end

    // eprom latch and program enable
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            ctrl_q.eprom_latch_enable <= CTRL_RESET[5];
            ctrl_q.eprom_program_enable <= CTRL_RESET[4];
        end else begin
            ctrl_q.eprom_latch_enable <= ep_lat_d;
            if (!ep_lat_d) begin
                ctrl_q.eprom_program_enable <= 1'b0;
            end else if (wr_ctrl && wr_bits.eprom_program_enable
                         && ctrl_q.eprom_latch_enable && (|ep_q.valid)) begin
                ctrl_q.eprom_program_enable <= 1'b1;
            end
        end
    end

    // eeprom latch, erase select and pump enable
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            ctrl_q.eeprom_latch_enable <= CTRL_RESET[1];
            ctrl_q.eeprom_erase_select <= CTRL_RESET[2];
            ctrl_q.eeprom_pump_enable <= CTRL_RESET[0];
        end else begin
            ctrl_q.eeprom_latch_enable <= ee_lat_d;
            if (!ee_lat_d) begin
                ctrl_q.eeprom_erase_select <= 1'b0;
                ctrl_q.eeprom_pump_enable <= 1'b0;
            end else begin
                if (wr_ctrl && !ee_sel_q && !ctrl_q.eeprom_pump_enable) begin
                    ctrl_q.eeprom_erase_select <= wr_bits.eeprom_erase_select;
                end
                // a zero write never clears the pump
                if (wr_ctrl && wr_bits.eeprom_pump_enable && ee_sel_q
                    && ctrl_q.eeprom_latch_enable) begin
                    ctrl_q.eeprom_pump_enable <= 1'b1;
                end
            end
        end
    end

    // options register: bits only go to zero, and only under eeprom latch
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            opts_q <= OPTS_RESET;
        end else if (wr_opts && ctrl_q.eeprom_latch_enable) begin
            opts_q <= opts_q & PWDATA[7:0] & OPTS_USED;
        end
    end

    // eprom byte latch for group programming
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            ep_q <= '0;
        end else if (!ep_lat_d) begin
            ep_q <= '0;
        end else if (mem_wr && ep_state == EP_LOAD && eepc_is_ep(region)) begin
            if (!(|ep_q.valid)) begin
                ep_q.group <= MEM_ADDR[15:4];
                ep_q.valid <= 16'h0001 << slot;
                ep_q.data[slot*8 +: 8] <= MEM_WDATA;
            end else if (MEM_ADDR[15:4] == ep_q.group) begin
                ep_q.valid <= ep_q.valid | (16'h0001 << slot);
                ep_q.data[slot*8 +: 8] <= ep_q.data[slot*8 +: 8] | MEM_WDATA;
            end
        end
    end

    // eeprom address and data capture while the pump is off
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            ee_sel_q <= 1'b0;
            ee_addr_q <= BYTE_ZERO;
            ee_data_q <= BYTE_ZERO;
        end else if (!ee_lat_d) begin
            ee_sel_q <= 1'b0;
            ee_addr_q <= BYTE_ZERO;
            ee_data_q <= BYTE_ZERO;
        end else if (mem_wr && region == RG_EE
                     && (ee_state == EE_LOAD || ee_state == EE_ERADDR)) begin
            ee_sel_q <= 1'b1;
            ee_addr_q <= MEM_ADDR[7:0];
            ee_data_q <= MEM_WDATA;
        end
    end

    // memory read path
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            mem_ack_q <= 1'b0;
            mem_rdata_q <= BYTE_ZERO;
        end else begin
            mem_ack_q <= MEM_REQ;
            if (MEM_REQ && !MEM_WE) begin
                case (region)
                    RG_EPMAIN, RG_EPVEC, RG_EPOPT: begin
                        if (ep_state != EP_READ) begin
                            mem_rdata_q <= BYTE_ZERO;
                        end else begin
                            mem_rdata_q <= EPROM_RDATA;
                        end
                    end
                    RG_EE: begin
                        mem_rdata_q <= EEPROM_RDATA;
                    end
                    default: begin
                        mem_rdata_q <= BYTE_ZERO;
                    end
                endcase
            end
        end
    end

    // array drive; in-progress states last until software or stop entry drops the latch
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            ep_prog_q <= 1'b0;
            ep_block_q <= 1'b0;
            ee_op_q <= '0;
            ee_blocked_q <= 1'b0;
        end else begin
            ep_prog_q <= ep_state == EP_PROG;
            ep_block_q <= ep_state != EP_READ;
            ee_op_q.addr <= ee_addr_q;
            ee_op_q.data <= ee_data_q;
            ee_op_q.erase <= ctrl_q.eeprom_erase_select;
            ee_op_q.pump <= (ee_state == EE_PROG || ee_state == EE_ERASE)
                            && !ee_fail;
            ee_blocked_q <= ctrl_q.eeprom_pump_enable && ee_fail;
        end
    end

    // wired-or interrupt request: pin low or any port b input high
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            woi_q <= 1'b0;
        end else begin
            woi_q <= ctrl_q.wired_or_irq_enable && WIRED_OR_MASK_OPTION
                     && (!WIRED_OR_IRQ_PIN_N || (|(PORTB_IN & ~PORTB_DDR)));
        end
    end

    always_comb begin
        PRDATA = prdata_q;
        PREADY = pready_q;
        PSLVERR = pslverr_q;
        MEM_RDATA = mem_rdata_q;
        MEM_ACK = mem_ack_q;
        WIRED_OR_IRQ = woi_q;
        EXTERNAL_CLOCK_OUTPUT = ctrl_q.external_clock_output;
        EPROM_PROGRAM_ACTIVE = ep_prog_q;
        EPROM_FETCH_BLOCKED = ep_block_q;
        EPROM_LATCH = ep_q;
        EEPROM_OP = ee_op_q;
        EEPROM_BLOCKED = ee_blocked_q;
        CTRL_VIEW = ctrl_q;
    end

endmodule // eepc_top

//--- tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import eepc_pkg::*;
    logic CLK_SYS = 1'b0, RST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h0, PRDATA, rd;
    logic PREADY, PSLVERR, er, MEM_REQ, MEM_WE, MEM_ACK, WIRED_OR_IRQ, EXTERNAL_CLOCK_OUTPUT;
    logic [15:0] MEM_ADDR;
    logic [7:0] MEM_WDATA, MEM_RDATA, EPROM_RDATA = 8'h00, EEPROM_RDATA = 8'h00;
    logic STOP_ENTRY = 1'b0, CAN_SLEEP = 1'b0, CAN_WAKE = 1'b0, WIRED_OR_MASK_OPTION = 1'b0;
    logic WIRED_OR_IRQ_PIN_N = 1'b1, EPROM_PROGRAM_ACTIVE, EPROM_FETCH_BLOCKED, EEPROM_BLOCKED;
    logic [7:0] PORTB_IN = 8'h00, PORTB_DDR = 8'h00;
    eepc_ep_latch_t EPROM_LATCH;
    eepc_ee_op_t EEPROM_OP;
    eepc_ctrl_t CTRL_VIEW;
    int n_errors = 0, checked = 0;

    always #2 CLK_SYS = ~CLK_SYS;

    eepc_top eepc_top_i (.CLK_SYS(CLK_SYS), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE), .MEM_ADDR(MEM_ADDR),
        .MEM_WDATA(MEM_WDATA), .MEM_RDATA(MEM_RDATA), .MEM_ACK(MEM_ACK),
        .EPROM_RDATA(EPROM_RDATA), .EEPROM_RDATA(EEPROM_RDATA), .STOP_ENTRY(STOP_ENTRY),
        .CAN_SLEEP(CAN_SLEEP), .CAN_WAKE(CAN_WAKE), .WIRED_OR_MASK_OPTION(WIRED_OR_MASK_OPTION),
        .WIRED_OR_IRQ_PIN_N(WIRED_OR_IRQ_PIN_N), .PORTB_IN(PORTB_IN), .PORTB_DDR(PORTB_DDR),
        .WIRED_OR_IRQ(WIRED_OR_IRQ), .EXTERNAL_CLOCK_OUTPUT(EXTERNAL_CLOCK_OUTPUT),
        .EPROM_PROGRAM_ACTIVE(EPROM_PROGRAM_ACTIVE), .EPROM_FETCH_BLOCKED(EPROM_FETCH_BLOCKED),
        .EPROM_LATCH(EPROM_LATCH), .EEPROM_OP(EEPROM_OP), .EEPROM_BLOCKED(EEPROM_BLOCKED),
        .CTRL_VIEW(CTRL_VIEW));

    eepc_cpu_model eepc_cpu_model_i (.clk(CLK_SYS), .mem_ack(MEM_ACK), .mem_rdata(MEM_RDATA),
        .mem_req(MEM_REQ), .mem_we(MEM_WE), .mem_addr(MEM_ADDR), .mem_wdata(MEM_WDATA));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge CLK_SYS);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK_SYS);
        PENABLE <= 1'b1;
        do @(posedge CLK_SYS); while (PREADY !== 1'b1);
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    task automatic wc(input logic [7:0] v);
        apb(1'b1, CTRL_BADDR, {24'h0, v});
    endtask

    task automatic rc(input logic [7:0] e, input string m);
        apb(1'b0, CTRL_BADDR, 32'h0);
        chk(rd, {24'h0, e}, m);
    endtask

    // one-cycle event: 0 stop entry, 1 can sleep, 2 can wake
    task automatic pulse(input int k);
        @(posedge CLK_SYS);
        case (k)
            0: STOP_ENTRY <= 1'b1;
            1: CAN_SLEEP <= 1'b1;
            default: CAN_WAKE <= 1'b1;
        endcase
        @(posedge CLK_SYS);
        {STOP_ENTRY, CAN_SLEEP, CAN_WAKE} <= 3'b000;
    endtask

    task automatic t_reset;
        rc(8'h00, "ctrl reset");
        apb(1'b0, OPTS_BADDR, 32'h0);
        chk(rd, 32'h3, "options reset");
        apb(1'b0, 12'h020, 32'h0);
        chk({31'h0, er}, 32'h1, "unmapped error");
        $display("test reset done");
    endtask

    task automatic t_eprom;
        wc(8'h10);
        rc(8'h00, "pgm without latch");
        wc(8'h20);
        wc(8'h30);
        rc(8'h20, "pgm without byte");
        chk(EPROM_FETCH_BLOCKED, 32'h1, "fetch blocked");
        eepc_cpu_model_i.access(1'b1, 16'h0405, 8'h05);
        eepc_cpu_model_i.access(1'b1, 16'h0405, 8'h30);
        eepc_cpu_model_i.access(1'b1, 16'h040F, 8'h81);
        eepc_cpu_model_i.access(1'b1, 16'h0415, 8'hFF);
        chk(EPROM_LATCH.valid, 32'h8020, "latched bytes");
        chk(EPROM_LATCH.data[47:40], 32'h35, "accumulated bits");
        chk(EPROM_LATCH.group, 32'h040, "latched group");
        EPROM_RDATA <= 8'h5A;
        eepc_cpu_model_i.access(1'b0, 16'h0405, 8'h00);
        chk(eepc_cpu_model_i.rd, 32'h0, "latched read");
        wc(8'h30);
        rc(8'h30, "pgm set");
        chk(EPROM_PROGRAM_ACTIVE, 32'h1, "prog active");
        wc(8'h20);
        rc(8'h30, "pgm zero ignored");
        wc(8'h00);
        rc(8'h00, "software end");
        chk(EPROM_PROGRAM_ACTIVE, 32'h0, "prog ended");
        chk(EPROM_LATCH.valid, 32'h0, "latch emptied");
        wc(8'h20);
        pulse(0);
        rc(8'h00, "stop clears");
        chk(EPROM_FETCH_BLOCKED, 32'h0, "fetch open");
        eepc_cpu_model_i.access(1'b0, 16'h0405, 8'h00);
        chk(eepc_cpu_model_i.rd, 32'h5A, "normal read");
        eepc_cpu_model_i.access(1'b0, 16'h7FF0, 8'h00);
        chk(eepc_cpu_model_i.rd, 32'h5A, "vector read");
        eepc_cpu_model_i.access(1'b0, 16'h0200, 8'h00);
        chk(eepc_cpu_model_i.rd, 32'h0, "unmapped read");
        $display("test eprom done");
    endtask

    task automatic t_eeprom;
        EEPROM_RDATA <= 8'hC3;
        eepc_cpu_model_i.access(1'b0, 16'h0100, 8'h00);
        chk(eepc_cpu_model_i.rd, 32'hC3, "eeprom read");
        wc(8'h02);
        wc(8'h03);
        rc(8'h02, "pump before data");
        wc(8'h06);
        eepc_cpu_model_i.access(1'b1, 16'h0110, 8'h77);
        wc(8'h03);
        rc(8'h07, "erase frozen");
        chk(EEPROM_OP, {14'h0, 8'h10, 8'h77, 2'b11}, "erase op");
        wc(8'h06);
        rc(8'h07, "pump held");
        wc(8'h00);
        rc(8'h00, "latch clear");
        apb(1'b1, OPTS_BADDR, 32'h1);
        apb(1'b0, OPTS_BADDR, 32'h0);
        chk(rd, 32'h3, "protect locked");
        wc(8'h02);
        apb(1'b1, OPTS_BADDR, 32'h1);
        apb(1'b0, OPTS_BADDR, 32'h0);
        chk(rd, 32'h1, "protect cleared");
        eepc_cpu_model_i.access(1'b1, 16'h0130, 8'h11);
        wc(8'h03);
        repeat (2) @(posedge CLK_SYS);
        chk(EEPROM_BLOCKED, 32'h1, "upper blocked");
        chk(EEPROM_OP.pump, 32'h0, "upper pump gated");
        wc(8'h00);
        wc(8'h02);
        eepc_cpu_model_i.access(1'b1, 16'h011F, 8'h22);
        wc(8'h03);
        repeat (2) @(posedge CLK_SYS);
        chk(EEPROM_BLOCKED, 32'h0, "lower open");
        chk(EEPROM_OP.pump, 32'h1, "lower pump on");
        pulse(0);
        rc(8'h00, "stop clears eeprom");
        $display("test eeprom done");
    endtask

    task automatic t_wor;
        wc(8'h80);
        rc(8'h00, "enable forced off");
        WIRED_OR_MASK_OPTION <= 1'b1;
        wc(8'h80);
        rc(8'h80, "enable set");
        WIRED_OR_IRQ_PIN_N <= 1'b0;
        repeat (3) @(posedge CLK_SYS);
        chk(WIRED_OR_IRQ, 32'h1, "pin request");
        WIRED_OR_IRQ_PIN_N <= 1'b1;
        PORTB_IN <= 8'h10;
        repeat (3) @(posedge CLK_SYS);
        chk(WIRED_OR_IRQ, 32'h1, "port input request");
        PORTB_DDR <= 8'h10;
        repeat (3) @(posedge CLK_SYS);
        chk(WIRED_OR_IRQ, 32'h0, "port output ignored");
        WIRED_OR_MASK_OPTION <= 1'b0;
        rc(8'h00, "enable dropped");
        $display("test wired-or done");
    endtask

    task automatic t_can;
        pulse(1);
        rc(8'h40, "asleep");
        wc(8'h08);
        rc(8'h48, "flag kept beside clock bit");
        chk(EXTERNAL_CLOCK_OUTPUT, 32'h1, "clock output bit");
        wc(8'h00);
        rc(8'h40, "flag read only");
        pulse(2);
        rc(8'h00, "awake");
        $display("test can flag done");
    endtask

    task automatic stop_test;
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge CLK_SYS);
        RST <= 1'b0;
        t_reset;
        t_eprom;
        t_eeprom;
        t_wor;
        t_can;
        stop_test;
    end

    initial begin
        repeat (20000) @(posedge CLK_SYS);
        n_errors++;
        stop_test;
    end
endmodule // tb_top

bind eepc_top eepc_asserts eepc_asserts_i (.CLK_SYS(CLK_SYS), .RST(RST), .MEM_REQ(MEM_REQ),
    .MEM_WE(MEM_WE), .MEM_ADDR(MEM_ADDR), .EPROM_RDATA(EPROM_RDATA), .MEM_RDATA(MEM_RDATA),
    .STOP_ENTRY(STOP_ENTRY), .CAN_SLEEP(CAN_SLEEP), .CAN_WAKE(CAN_WAKE),
    .WIRED_OR_MASK_OPTION(WIRED_OR_MASK_OPTION), .WIRED_OR_IRQ_PIN_N(WIRED_OR_IRQ_PIN_N),
    .WIRED_OR_IRQ(WIRED_OR_IRQ), .EPROM_PROGRAM_ACTIVE(EPROM_PROGRAM_ACTIVE),
    .EPROM_LATCH(EPROM_LATCH), .CTRL_VIEW(CTRL_VIEW));
